// ===== logic/cal_slot_pkg.sv
// shared constants and types for the calibration slot manager
package cal_slot_pkg;
    localparam int          CAL_W      = 32;
    localparam int          AREA_N     = 6;
    localparam int          PW_DIGITS  = 4;
    localparam int          SPW_MIN    = 6;
    localparam int          SPW_MAX    = 20;
    localparam logic [CAL_W-1:0] CAL_RST = 32'h0000_0000;
    localparam logic [15:0] PW_RST     = 16'h0000;
    // keypad codes; 4'h0 to 4'h9 are digits
    localparam logic [3:0]  KEY_DIG_MAX = 4'h9;
    localparam logic [3:0]  KEY_ENTER   = 4'ha;
    localparam logic [3:0]  KEY_CLEAR   = 4'hb;
    localparam logic [3:0]  KEY_RESET   = 4'hc;
    localparam logic [3:0]  KEY_MENU    = 4'hd;
    localparam logic [3:0]  KEY_YES     = 4'h1;
    // menu screens shown in turn by the menu key
    localparam logic [1:0]  SCR_PASSWD  = 2'h0;
    localparam logic [1:0]  SCR_PREV    = 2'h1;
    localparam logic [1:0]  SCR_FACT    = 2'h2;
    // punctuation allowed in the special password
    localparam logic [63:0] PUNCT_SET   = 64'h2140_2324_255e_262a;

    typedef enum logic [2:0] {
        AREA_WORK, AREA_PRIOR, AREA_OLDEST, AREA_FACTORY, AREA_MASTER, AREA_FIRST
    } area_t;

    typedef enum logic [1:0] {
        OP_SAVE, OP_COPY, OP_COMPACT, OP_FACTORY_LOAD
    } cal_op_t;

    typedef enum logic [1:0] {
        RES_OK, RES_BAD_PW, RES_REFUSED
    } result_t;
endpackage

// ===== logic/calibration_slot_manager.sv
// calibration slot manager: six flash areas, history rotation, password gating
// How it works
// - six separate areas: working, prior, oldest, factory, master, first
// - area contents stay until a flash compaction is run
// - the working area is the active calibration
// - a calibration save writes new values into working
// - save moves working to prior, prior to oldest, drops old oldest
// - copy into working rotates history the same way; other areas untouched
// - host names a source and a destination area for a copy
// - stores into factory refused unless special password unlocks them
// - correct calibration password needed before any store; compaction runs without it
// - special password: 6..20 chars, upper letter, digit, punctuation, no space
// - factory calibration loads identical values into factory, master, first
// - saves and copies into working keep preceding values in prior and oldest for later restore
// - restore menus only from command entry; clear or reset returns there
// - key 1 then enter on a restore screen prompts for the password
// - correct 4-digit password in restore-previous makes prior values active
// - correct 4-digit password in restore-factory makes factory values active
module calibration_slot_manager
    import cal_slot_pkg::*;
#(
    parameter logic [15:0]          USER_PW    = PW_RST,
    parameter bit                   UNLOCK_EN  = 1'b0,
    parameter logic [SPW_MAX*8-1:0] SPECIAL_PW = '0,
    parameter int                   SPECIAL_LEN = SPW_MIN
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire cal_op_t            cmd_op,
    input  wire area_t              cmd_src,
    input  wire area_t              cmd_dst,
    input  wire logic [CAL_W-1:0]   cmd_data,
    input  wire logic [15:0]        cmd_pw,
    input  wire logic               spw_valid,
    input  wire logic [7:0]         spw_char,
    input  wire logic               spw_last,
    output logic                    spw_ok_r,
    input  wire logic               key_valid,
    input  wire logic [3:0]         key_code,
    output logic                    entry_status,
    output logic                    pw_prompt,
    output logic [1:0]              menu_screen_r,
    output logic                    resp_valid_r,
    output result_t                 resp_code_r,
    input  wire area_t              rd_sel,
    output logic [CAL_W-1:0]        rd_data_r,
    output logic [CAL_W-1:0]        active_cal,
    output logic [AREA_N-1:0]       area_vld_r
);
    typedef enum {KP_ENTRY, KP_MENU, KP_ARMED, KP_PASS} kp_state_t;

    kp_state_t          kp_r;
    logic [15:0]        kp_pw_r;
    logic [2:0]         kp_cnt_r;
    logic [CAL_W-1:0]   area_r   [AREA_N];
    logic [CAL_W-1:0]   area_nxt [AREA_N];
    logic [AREA_N-1:0]  vld_nxt;
    logic [AREA_N*CAL_W-1:0] areas_flat;
    logic [4:0]         spw_cnt_r;
    logic               spw_alpha_r, spw_digit_r, spw_punct_r, spw_bad_r, spw_match_r;
    logic               spw_char_ok, spw_len_ok, spw_class_ok;
    logic               kp_go, kp_clear, req_go, pw_ok, lock_hit, commit;
    cal_op_t            req_op;
    area_t              req_src, req_dst;
    logic [CAL_W-1:0]   req_data;

    // character classes for the special password
    function automatic logic is_upper(input logic [7:0] c);
        return c >= 8'h41 && c <= 8'h5a;
    endfunction
    function automatic logic is_digit(input logic [7:0] c);
        return c >= 8'h30 && c <= 8'h39;
    endfunction
    function automatic logic is_punct(input logic [7:0] c);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (PUNCT_SET[i*8 +: 8] == c) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // keypad front end
    assign kp_clear     = key_valid && (key_code == KEY_CLEAR || key_code == KEY_RESET);
    assign kp_go        = (kp_r == KP_PASS) && key_valid && key_code == KEY_ENTER;
    assign entry_status = (kp_r == KP_ENTRY);
    assign pw_prompt    = (kp_r == KP_PASS);

    // keypad menu walk; restore screens reachable only from command entry
    // key 1 on the password-change screen does nothing; only the two restore screens arm
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kp_r          <= KP_ENTRY;
            menu_screen_r <= SCR_PASSWD;
        end else if (kp_clear) begin
            kp_r <= KP_ENTRY;
        end else if (key_valid) begin
            unique case (kp_r)
                KP_ENTRY: if (key_code == KEY_MENU) begin
                    kp_r          <= KP_MENU;
                    menu_screen_r <= SCR_PASSWD;
                end
                KP_MENU: if (key_code == KEY_MENU) begin
                    menu_screen_r <= (menu_screen_r == SCR_FACT) ? SCR_PASSWD : 2'(menu_screen_r + 2'h1);
                end else if (key_code == KEY_YES && menu_screen_r != SCR_PASSWD) begin
                    kp_r <= KP_ARMED;
                end
                KP_ARMED: if (key_code == KEY_ENTER) begin
                    kp_r <= KP_PASS;
                end
                KP_PASS: if (key_code == KEY_ENTER) begin
                    kp_r <= KP_ENTRY;
                end
            endcase
        end
    end

    // keypad password digits, first four kept
    // digits past the fourth are dropped, so a stray key cannot push out the first one
    always_ff @(posedge clk) begin
        if (sys_rst || kp_r != KP_PASS) begin
            kp_pw_r  <= PW_RST;
            kp_cnt_r <= 3'h0;
        end else if (key_valid && key_code <= KEY_DIG_MAX && kp_cnt_r < 3'(PW_DIGITS)) begin
            kp_pw_r  <= {kp_pw_r[11:0], key_code};
            kp_cnt_r <= 3'(kp_cnt_r + 3'h1);
        end
    end

    // special password checker fed one character at a time
    // a string longer than the limit fails the length check and can never unlock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spw_cnt_r   <= 5'h00;
            spw_alpha_r <= 1'b0;
            spw_digit_r <= 1'b0;
            spw_punct_r <= 1'b0;
            spw_bad_r   <= 1'b0;
            spw_match_r <= 1'b1;
        end else if (spw_valid && spw_last) begin
            spw_cnt_r   <= 5'h00;
            spw_alpha_r <= 1'b0;
            spw_digit_r <= 1'b0;
            spw_punct_r <= 1'b0;
            spw_bad_r   <= 1'b0;
            spw_match_r <= 1'b1;
        end else if (spw_valid) begin
            spw_cnt_r   <= (spw_cnt_r < 5'(SPW_MAX)) ? 5'(spw_cnt_r + 5'h01) : spw_cnt_r;
            spw_alpha_r <= spw_alpha_r | is_upper(spw_char);
            spw_digit_r <= spw_digit_r | is_digit(spw_char);
            spw_punct_r <= spw_punct_r | is_punct(spw_char);
            spw_bad_r   <= spw_bad_r | (spw_cnt_r >= 5'(SPW_MAX))
                         | !(is_upper(spw_char) | is_digit(spw_char) | is_punct(spw_char));
            spw_match_r <= spw_match_r && spw_cnt_r < 5'(SPW_MAX)
                         && SPECIAL_PW[spw_cnt_r*8 +: 8] == spw_char;
        end
    end

    // verdict on the string that ends with the present character
    always_comb begin
        spw_char_ok  = is_upper(spw_char) | is_digit(spw_char) | is_punct(spw_char);
        spw_len_ok   = spw_cnt_r < 5'(SPW_MAX) && 6'(spw_cnt_r) + 6'h01 >= 6'(SPW_MIN)
                    && 6'(spw_cnt_r) + 6'h01 == 6'(SPECIAL_LEN);
        spw_class_ok = (spw_alpha_r | is_upper(spw_char)) && (spw_digit_r | is_digit(spw_char))
                    && (spw_punct_r | is_punct(spw_char));
    end

    // unlock flag: a finished good string sets it, a factory store uses it up
    // a string end wins over a same-cycle clear, so a fresh unlock is never lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spw_ok_r <= 1'b0;
        end else if (spw_valid && spw_last) begin
            spw_ok_r <= UNLOCK_EN && !spw_bad_r && spw_char_ok && spw_len_ok && spw_class_ok
                && spw_match_r && SPECIAL_PW[spw_cnt_r*8 +: 8] == spw_char;
        end else if (commit && lock_hit) begin
            spw_ok_r <= 1'b0;
        end
    end

    // request merge; keypad restore wins and stalls the host for that cycle
    // the host only sees ready low for one cycle and keeps its request standing
    assign cmd_ready = !kp_go;
    always_comb begin
        req_go   = kp_go || cmd_valid;
        req_op   = kp_go ? OP_COPY : cmd_op;
        req_src  = kp_go ? ((menu_screen_r == SCR_PREV) ? AREA_PRIOR : AREA_FACTORY) : cmd_src;
        req_dst  = kp_go ? AREA_WORK : cmd_dst;
        req_data = cmd_data;
        pw_ok    = kp_go ? (kp_cnt_r == 3'(PW_DIGITS) && kp_pw_r == USER_PW) : (cmd_pw == USER_PW);
        lock_hit = (req_op == OP_FACTORY_LOAD) || (req_op == OP_COPY && req_dst == AREA_FACTORY);
    end
    // store allowed only with the right password (compaction needs none) and, for factory, the unlock
    assign commit = req_go && (pw_ok || req_op == OP_COMPACT) && (!lock_hit || spw_ok_r);

    // next contents of the six areas
    always_comb begin
        for (int i = 0; i < AREA_N; i++) begin
            area_nxt[i] = area_r[i];
        end
        vld_nxt = area_vld_r;
        if (commit) begin
            unique case (req_op)
                OP_SAVE, OP_COPY: if (req_op == OP_SAVE || req_dst == AREA_WORK) begin
                    area_nxt[AREA_WORK]   = (req_op == OP_SAVE) ? req_data : area_r[req_src];
                    area_nxt[AREA_PRIOR]  = area_r[AREA_WORK];
                    area_nxt[AREA_OLDEST] = area_r[AREA_PRIOR];
                    vld_nxt[AREA_WORK]    = (req_op == OP_SAVE) | area_vld_r[req_src];
                    vld_nxt[AREA_PRIOR]   = area_vld_r[AREA_WORK];
                    vld_nxt[AREA_OLDEST]  = area_vld_r[AREA_PRIOR];
                end else begin
                    area_nxt[req_dst] = area_r[req_src];
                    vld_nxt[req_dst]  = area_vld_r[req_src];
                end
                OP_COMPACT: begin
                    area_nxt[AREA_PRIOR]  = CAL_RST;
                    area_nxt[AREA_OLDEST] = CAL_RST;
                    vld_nxt[AREA_PRIOR]   = 1'b0;
                    vld_nxt[AREA_OLDEST]  = 1'b0;
                end
                OP_FACTORY_LOAD: begin
                    area_nxt[AREA_FACTORY] = req_data;
                    area_nxt[AREA_MASTER]  = req_data;
                    area_nxt[AREA_FIRST]   = req_data;
                    vld_nxt[AREA_FACTORY]  = 1'b1;
                    vld_nxt[AREA_MASTER]   = 1'b1;
                    vld_nxt[AREA_FIRST]    = 1'b1;
                end
            endcase
        end
    end

    // the six storage areas
    // reset stands for an erased flash: every area empty and marked invalid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < AREA_N; i++) begin
                area_r[i] <= CAL_RST;
            end
            area_vld_r <= '0;
        end else begin
            for (int i = 0; i < AREA_N; i++) begin
                area_r[i] <= area_nxt[i];
            end
            area_vld_r <= vld_nxt;
        end
    end

    // flat view of all areas
    generate
        for (genvar g = 0; g < AREA_N; g++) begin : g_flat
            assign areas_flat[g*CAL_W +: CAL_W] = area_r[g];
        end
    endgenerate

    assign active_cal = area_r[AREA_WORK];

    // result of each request, one-cycle pulse
    // a refused factory store is told apart from a wrong password
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_valid_r <= 1'b0;
            resp_code_r  <= RES_OK;
        end else begin
            resp_valid_r <= req_go;
            resp_code_r  <= commit ? RES_OK : (pw_ok || req_op == OP_COMPACT) ? RES_REFUSED : RES_BAD_PW;
        end
    end

    // area readback for dump queries
    // one cycle of latency; rd_sel may change on every clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_r <= CAL_RST;
        end else begin
            rd_data_r <= area_r[rd_sel];
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_save_work: assert property (commit && req_op == OP_SAVE |=> active_cal == $past(req_data))
        else $error("save did not write working");
    chk_save_rotate: assert property (commit && req_op == OP_SAVE |=>
        area_r[AREA_PRIOR] == $past(area_r[AREA_WORK]) && area_r[AREA_OLDEST] == $past(area_r[AREA_PRIOR]))
        else $error("save rotation wrong");
    chk_copy_rotate: assert property (commit && req_op == OP_COPY && req_dst == AREA_WORK |=>
        area_r[AREA_PRIOR] == $past(area_r[AREA_WORK]) && $stable(area_r[AREA_MASTER])
        && $stable(area_r[AREA_FACTORY]) && $stable(area_r[AREA_FIRST]))
        else $error("copy to working rotation wrong");
    chk_copy_dest: assert property (commit && req_op == OP_COPY && req_dst != AREA_WORK |=>
        area_r[$past(req_dst)] == $past(area_r[req_src]))
        else $error("copy destination wrong");
    chk_factory_lock: assert property (req_go && lock_hit && !spw_ok_r |=> $stable(areas_flat))
        else $error("factory store not refused");
    chk_bad_pw: assert property (req_go && !pw_ok && req_op != OP_COMPACT |=>
        $stable(areas_flat) ##0 resp_valid_r && resp_code_r == RES_BAD_PW)
        else $error("wrong password changed areas");
    chk_factory_load: assert property (commit && req_op == OP_FACTORY_LOAD |=>
        area_r[AREA_FACTORY] == area_r[AREA_MASTER] && area_r[AREA_MASTER] == area_r[AREA_FIRST])
        else $error("factory load not identical");
    chk_prompt: assert property (kp_r == KP_ARMED && key_valid && key_code == KEY_ENTER && !kp_clear
        |=> pw_prompt [*1] ##0 kp_cnt_r == 3'h0)
        else $error("no password prompt");
    chk_clear_entry: assert property (kp_clear |=> entry_status)
        else $error("clear did not return to entry");
    chk_restore: assert property (kp_go && pw_ok |=>
        active_cal == ($past(menu_screen_r) == SCR_PREV ? $past(area_r[AREA_PRIOR]) : $past(area_r[AREA_FACTORY])))
        else $error("restore loaded wrong values");
    chk_spw_unlock: assert property ($rose(spw_ok_r) |-> $past(spw_valid && spw_last) && UNLOCK_EN)
        else $error("unlock without full string");

    // compaction, refusal, acknowledge, unlock length and keypad order
    chk_compact_keep: assert property (commit && req_op == OP_COMPACT |=>
        $stable(active_cal) && $stable(area_r[AREA_FACTORY]) && $stable(area_r[AREA_MASTER])
        && $stable(area_r[AREA_FIRST]) && area_vld_r[AREA_PRIOR] == 1'b0 && area_vld_r[AREA_OLDEST] == 1'b0)
        else $error("compaction touched kept areas");
    chk_factory_refused: assert property (req_go && pw_ok && lock_hit && !spw_ok_r |=>
        resp_valid_r && resp_code_r == RES_REFUSED)
        else $error("factory store not reported refused");
    chk_store_ok: assert property (req_go && pw_ok && !lock_hit |=>
        resp_valid_r && resp_code_r == RES_OK)
        else $error("good store not acknowledged");
    chk_unlock_len: assert property ($rose(spw_ok_r) |->
        $past(spw_cnt_r) >= 5'(SPW_MIN - 1) && $past(spw_cnt_r) < 5'(SPW_MAX))
        else $error("unlock with wrong length");
    chk_menu_entry: assert property (kp_r == KP_MENU |->
        $past(kp_r) == KP_ENTRY || $past(kp_r) == KP_MENU)
        else $error("menu entered from outside command entry");
    chk_prompt_armed: assert property (pw_prompt && !$past(pw_prompt) |-> $past(kp_r) == KP_ARMED)
        else $error("password prompt without armed restore");

    cov_save: cover property (commit && req_op == OP_SAVE ##1 commit && req_op == OP_SAVE);
    cov_copy_work: cover property (commit && req_op == OP_COPY && req_dst == AREA_WORK);
    cov_restore: cover property (kp_go && pw_ok);
    cov_bad_pw: cover property (req_go && !pw_ok);
    cov_factory_lock: cover property (req_go && lock_hit && !spw_ok_r);
endmodule

// ===== verification/host_panel.sv
// partner model: remote command host and front panel keypad
module host_panel
    import cal_slot_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        cmd_ready,
    input  wire logic        resp_valid_r,
    input  wire result_t     resp_code_r,
    output logic             cmd_valid,
    output cal_op_t          cmd_op,
    output area_t            cmd_src,
    output area_t            cmd_dst,
    output logic [CAL_W-1:0] cmd_data,
    output logic [15:0]      cmd_pw,
    output logic             spw_valid,
    output logic [7:0]       spw_char,
    output logic             spw_last,
    output logic             key_valid,
    output logic [3:0]       key_code
);
    timeunit 1ns;
    timeprecision 100ps;
    result_t last_code;
    logic    got_resp;
    // everything idle at time zero
    initial begin
        {cmd_valid, spw_valid, spw_last, key_valid, key_code, spw_char, cmd_data, cmd_pw} = '0;
        cmd_op  = OP_SAVE;
        cmd_src = AREA_WORK;
        cmd_dst = AREA_WORK;
    end
    // host request held until taken; a released data bus shows the inverse
    task host(input cal_op_t op, input area_t s, input area_t d, input logic [31:0] v, input logic [15:0] pw);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_src   = s;
        cmd_dst   = d;
        cmd_data  = v;
        cmd_pw    = pw;
        // ready settles just after the edge and stands until the next one
        while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_data = ~v;
        got_resp = resp_valid_r;
        last_code = resp_code_r;
    endtask
    // one key pulse; the answer, if any, is caught just after the next edge
    task key(input logic [3:0] k);
        @(posedge clk);
        #1;
        {key_valid, key_code} = {1'b1, k};
        @(posedge clk);
        #1;
        {key_valid, key_code} = {1'b0, ~k};
        got_resp = resp_valid_r;
        last_code = resp_code_r;
    endtask
    // four password digits, most significant first
    task pin(input logic [15:0] p);
        for (int i = 3; i >= 0; i--) key(p[i*4+:4]);
    endtask
    // special password characters back to back
    task spw(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk);
            #1;
            {spw_valid, spw_char, spw_last} = {1'b1, s[i], i == s.len() - 1};
        end
        @(posedge clk);
        #1;
        spw_valid = 1'b0;
    endtask
endmodule

// ===== verification/calibration_slot_manager_tb.sv
// self-checking bench for the calibration slot manager
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module calibration_slot_manager_tb
    import cal_slot_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] PW  = 16'h1234;
    localparam logic [15:0] BAD = 16'h1243;
    typedef struct {cal_op_t op; logic [31:0] d; logic [15:0] pw; result_t rc; logic [31:0] w, p, o;} row_t;
    logic             clk, sys_rst, cmd_valid, cmd_ready, spw_valid, spw_last, spw_ok_r;
    logic             key_valid, entry_status, pw_prompt, resp_valid_r;
    cal_op_t          cmd_op;
    area_t            cmd_src, cmd_dst, rd_sel;
    result_t          resp_code_r;
    logic [CAL_W-1:0] cmd_data, rd_data_r, active_cal;
    logic [15:0]      cmd_pw;
    logic [7:0]       spw_char;
    logic [3:0]       key_code;
    logic [1:0]       menu_screen_r;
    logic [5:0]       area_vld_r;
    int               n_fail = 0;
    int               checks_done = 0;
    row_t             rows [7];

    calibration_slot_manager #(.USER_PW(PW), .UNLOCK_EN(1'b1), .SPECIAL_PW({112'h0, "DCB!1A"}),
        .SPECIAL_LEN(6)) u_calibration_slot_manager (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_src(cmd_src), .cmd_dst(cmd_dst), .cmd_data(cmd_data),
        .cmd_pw(cmd_pw), .spw_valid(spw_valid), .spw_char(spw_char), .spw_last(spw_last), .spw_ok_r(spw_ok_r),
        .key_valid(key_valid), .key_code(key_code), .entry_status(entry_status), .pw_prompt(pw_prompt),
        .menu_screen_r(menu_screen_r), .resp_valid_r(resp_valid_r), .resp_code_r(resp_code_r),
        .rd_sel(rd_sel), .rd_data_r(rd_data_r), .active_cal(active_cal), .area_vld_r(area_vld_r));
    host_panel u_host_panel (.clk(clk), .cmd_ready(cmd_ready), .resp_valid_r(resp_valid_r),
        .resp_code_r(resp_code_r), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_src(cmd_src), .cmd_dst(cmd_dst),
        .cmd_data(cmd_data), .cmd_pw(cmd_pw), .spw_valid(spw_valid), .spw_char(spw_char), .spw_last(spw_last),
        .key_valid(key_valid), .key_code(key_code));

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task report_and_stop;
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // read back one area through the registered readback port
    task rd(input area_t a, input logic [31:0] e);
        @(posedge clk);
        #1;
        rd_sel = a;
        @(posedge clk);
        #1;
        `CHK(rd_data_r, e)
    endtask
    // response of the last request
    task resp(input result_t rc);
        `CHK(u_host_panel.got_resp, 1'b1)
        `CHK(u_host_panel.last_code, rc)
    endtask
    // keypad restore: menu presses, yes, enter, password, enter
    task restore(input int n, input logic [1:0] scr, input logic [15:0] p);
        repeat (n) u_host_panel.key(KEY_MENU);
        `CHK(menu_screen_r, scr)
        u_host_panel.key(KEY_YES);
        u_host_panel.key(KEY_ENTER);
        `CHK(pw_prompt, 1'b1)
        u_host_panel.pin(p);
        fork
            u_host_panel.key(KEY_ENTER);
            begin
                @(posedge clk);
                #2;
                `CHK(cmd_ready, 1'b0)
            end
        join
    endtask

    // watchdog
    initial begin
        #100000;
        n_fail++;
        report_and_stop;
    end

    initial begin
        rows[0] = '{OP_SAVE, 32'h11, PW, RES_OK, 32'h11, 32'h0, 32'h0};
        rows[1] = '{OP_SAVE, 32'h22, PW, RES_OK, 32'h22, 32'h11, 32'h0};
        rows[2] = '{OP_SAVE, 32'h33, PW, RES_OK, 32'h33, 32'h22, 32'h11};
        rows[3] = '{OP_SAVE, 32'h44, BAD, RES_BAD_PW, 32'h33, 32'h22, 32'h11};
        rows[4] = '{OP_SAVE, 32'h44, PW, RES_OK, 32'h44, 32'h33, 32'h22};
        rows[5] = '{OP_FACTORY_LOAD, 32'h55, PW, RES_REFUSED, 32'h44, 32'h33, 32'h22};
        rows[6] = '{OP_COPY, 32'h66, PW, RES_REFUSED, 32'h44, 32'h33, 32'h22};
        sys_rst = 1'b1;
        rd_sel = AREA_WORK;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        `CHK(area_vld_r, 6'h00)
        `CHK(entry_status, 1'b1)
        `CHK(cmd_ready, 1'b1)
        // saves, a bad password and two refused factory stores
        foreach (rows[i]) begin
            u_host_panel.host(rows[i].op, AREA_WORK, AREA_FACTORY, rows[i].d, rows[i].pw);
            resp(rows[i].rc);
            rd(AREA_WORK, rows[i].w);
            rd(AREA_PRIOR, rows[i].p);
            rd(AREA_OLDEST, rows[i].o);
            `CHK(active_cal, rows[i].w)
        end
        // special password: lower case refused, proper one unlocks factory
        u_host_panel.spw("a1!bcd");
        `CHK(spw_ok_r, 1'b0)
        u_host_panel.spw("A1!BCD");
        `CHK(spw_ok_r, 1'b1)
        u_host_panel.host(OP_FACTORY_LOAD, AREA_WORK, AREA_FACTORY, 32'h55, PW);
        resp(RES_OK);
        `CHK(spw_ok_r, 1'b0)
        for (int a = 3; a < 6; a++) rd(area_t'(a), 32'h55);
        // copy factory into working rotates history
        u_host_panel.host(OP_COPY, AREA_FACTORY, AREA_WORK, 32'h0, PW);
        resp(RES_OK);
        rd(AREA_WORK, 32'h55);
        rd(AREA_PRIOR, 32'h44);
        rd(AREA_OLDEST, 32'h33);
        rd(AREA_FACTORY, 32'h55);
        `CHK(area_vld_r, 6'h3f)
        // keypad restore of the previous values
        restore(2, SCR_PREV, PW);
        resp(RES_OK);
        `CHK(active_cal, 32'h44)
        `CHK(entry_status, 1'b1)
        rd(AREA_PRIOR, 32'h55);
        // clear leaves the menu screen, reset leaves an armed restore screen
        u_host_panel.key(KEY_MENU);
        `CHK(entry_status, 1'b0)
        u_host_panel.key(KEY_CLEAR);
        `CHK(entry_status, 1'b1)
        u_host_panel.key(KEY_MENU);
        u_host_panel.key(KEY_MENU);
        u_host_panel.key(KEY_YES);
        u_host_panel.key(KEY_RESET);
        `CHK(entry_status, 1'b1)
        `CHK(pw_prompt, 1'b0)
        // factory restore: wrong password first, then the right one
        restore(3, SCR_FACT, BAD);
        resp(RES_BAD_PW);
        `CHK(active_cal, 32'h44)
        restore(3, SCR_FACT, PW);
        resp(RES_OK);
        `CHK(active_cal, 32'h55)
        // compaction drops the history only
        u_host_panel.host(OP_COMPACT, AREA_WORK, AREA_WORK, 32'h0, BAD);
        resp(RES_OK);
        `CHK(area_vld_r, 6'h39)
        rd(AREA_OLDEST, 32'h0);
        rd(AREA_FIRST, 32'h55);
        // plain copy into a history area
        u_host_panel.host(OP_COPY, AREA_WORK, AREA_OLDEST, 32'h0, PW);
        resp(RES_OK);
        rd(AREA_OLDEST, 32'h55);
        `CHK(area_vld_r, 6'h3d)
        // reset in mid-run empties every area again
        @(posedge clk);
        #1;
        sys_rst = 1'b1;
        @(posedge clk);
        #1;
        sys_rst = 1'b0;
        `CHK(area_vld_r, 6'h00)
        `CHK(active_cal, 32'h0)
        `CHK(entry_status, 1'b1)
        report_and_stop;
    end
endmodule
